// ### csic_top.sv
// configurator top: apb registers, trigger edge detect, write table sequencer
// assumes a 10 MHz clk_in, pins from outside the clock domain, pulled-up data line
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "csic_regs.svh"
module csic_top
  import csic_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `CSIC_DEV_ADDR
)(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic config_trigger_in,
  input wire logic [3:0] transceiver_freq_sel_a_in,
  input wire logic [3:0] transceiver_freq_sel_b_in,
  input wire logic [3:0] memory_freq_sel_a_in,
  input wire logic [3:0] memory_freq_sel_b_in,
  output logic programming_complete_out,
  output logic scl_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);
  // -----------------------------
  // table lookup functions
  // -----------------------------
  function automatic logic [7:0] xcvr_div(input logic [3:0] code);
    unique case (code)
      4'h1: xcvr_div = `CSIC_XDIV1;
      4'h2: xcvr_div = `CSIC_XDIV2;
      4'h3: xcvr_div = `CSIC_XDIV3;
      4'h4: xcvr_div = `CSIC_XDIV4;
      default: xcvr_div = `CSIC_XDIV0;  // unlisted codes fall back to code 0
    endcase
  endfunction : xcvr_div
  function automatic logic [7:0] mem_div(input logic [3:0] code);
    unique case (code)
      4'h1: mem_div = `CSIC_MDIV1;
      4'h2: mem_div = `CSIC_MDIV2;
      4'h3: mem_div = `CSIC_MDIV3;
      4'h4: mem_div = `CSIC_MDIV4;
      default: mem_div = `CSIC_MDIV0;
    endcase
  endfunction : mem_div
  // -----------------------------
  // synchronisers
  // -----------------------------
  logic trig_s1_r, trig_s2_r, trig_d_r;
  logic [15:0] sel_s1_r, sel_s2_r;     // {mem b, mem a, xcvr b, xcvr a}
  logic sda_s1_r, sda_s2_r;
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      {trig_s1_r, trig_s2_r, trig_d_r, sda_s1_r, sda_s2_r} <= 5'h03;
      {sel_s1_r, sel_s2_r} <= 32'h0000_0000;
    end
    else
    begin
      {trig_s1_r, trig_s2_r, trig_d_r} <= {config_trigger_in, trig_s1_r, trig_s2_r};
      {sda_s1_r, sda_s2_r} <= {sda_in, sda_s1_r};
      sel_s1_r <= {memory_freq_sel_b_in, memory_freq_sel_a_in, transceiver_freq_sel_b_in, transceiver_freq_sel_a_in};
      sel_s2_r <= sel_s1_r;
    end
  // -----------------------------
  // apb slave
  // -----------------------------
  logic [31:0] ctrl_r;                 // software control
  logic sw_prev_r;                     // last software start level
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  logic done_r, nack_err_r;
  logic [3:0] step_r;
  csic_top_state_t st_r;
  wire setup = psel_in && !penable_in;
  wire hit_ctrl = (paddr_in == `CSIC_OFS_CTRL);
  wire hit_stat = (paddr_in == `CSIC_OFS_STATUS);
  wire wr_ctrl = psel_in && penable_in && pready_r && pwrite_in && hit_ctrl;
  wire [31:0] stat_word = {20'h00000, step_r, 5'h00, nack_err_r, st_r != T_IDLE, done_r};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_r : hit_stat ? stat_word : 32'h0000_0000;
  // one access cycle, read data captured in setup
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= setup;
      pslverr_r <= setup && !(hit_ctrl || (hit_stat && !pwrite_in));  // unmapped or read-only
      prdata_r <= (setup && !pwrite_in) ? rd_mux : 32'h0000_0000;
    end
  // control register write; status is read-only
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
      ctrl_r <= `CSIC_CTRL_RESET;
    else if (wr_ctrl)
      ctrl_r <= pwdata_in & 32'h000f_fff3;
  // -----------------------------
  // trigger and select source
  // -----------------------------
  wire trig_evt = (trig_s2_r && !trig_d_r) || (ctrl_r[`CSIC_CTRL_START_BIT] && !sw_prev_r);
  wire [15:0] sel_eff = ctrl_r[`CSIC_CTRL_SRC_BIT] ? ctrl_r[`CSIC_CTRL_SEL_MSB:`CSIC_CTRL_SEL_LSB] : sel_s2_r;
  logic pending_r;                     // edge seen during a run
  wire start_run = (st_r == T_IDLE) && (trig_evt || pending_r);
  wire pending_nxt = (trig_evt && st_r != T_IDLE) || (pending_r && !start_run);  // set wins
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
      {sw_prev_r, pending_r} <= 2'b00;
    else
      {sw_prev_r, pending_r} <= {ctrl_r[`CSIC_CTRL_START_BIT], pending_nxt};
  // -----------------------------
  // write table sequencer
  // -----------------------------
  logic [15:0] snap_r;                 // selects frozen for the run
  logic go_r;
  logic [15:0] entry_r;                // {register, data}
  logic eng_done, eng_nack;
  wire [3:0] xa = snap_r[3:0];
  wire [3:0] xb = snap_r[7:4];
  wire [3:0] ma = snap_r[11:8];
  wire [3:0] mb = snap_r[15:12];
  wire [7:0] ch_reg = `CSIC_REG_CH_BASE + {4'h0, step_r - 4'h1};
  wire [7:0] ch_dat = (step_r == 4'h1) ? xcvr_div(xa) :
                      (step_r == 4'h2) ? xcvr_div(xb) :
                      (step_r == 4'h3) ? mem_div(ma) : mem_div(mb);
  wire [15:0] entry_nxt = (step_r == 4'h0) ? {`CSIC_REG_PREAMBLE, `CSIC_DAT_PREAMBLE} :
                          (step_r == 4'h5) ? {`CSIC_REG_UPDATE, `CSIC_DAT_UPDATE} :
                          (step_r == 4'h6) ? {`CSIC_REG_OUT_EN, `CSIC_DAT_OUT_EN} : {ch_reg, ch_dat};
  // run control; asynchronous low reset clears everything
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_r <= T_IDLE;
      step_r <= 4'h0;
      snap_r <= 16'h0000;
      go_r <= 1'b0;
      entry_r <= 16'h0000;
      done_r <= 1'b0;
      nack_err_r <= 1'b0;
    end
    else
    begin
      go_r <= 1'b0;
      unique case (st_r)
        T_IDLE:
          if (start_run)
          begin
            snap_r <= sel_eff;
            step_r <= 4'h0;
            done_r <= 1'b0;
            nack_err_r <= 1'b0;
            st_r <= T_SEND;
          end
        T_SEND:
        begin
          entry_r <= entry_nxt;
          go_r <= 1'b1;
          st_r <= T_WAIT;
        end
        T_WAIT:
          if (eng_done)
          begin
            if (eng_nack)
            begin
              nack_err_r <= 1'b1;    // abort, done stays low
              st_r <= T_IDLE;
            end
            else if (step_r == `CSIC_LAST_STEP)
            begin
              done_r <= 1'b1;
              st_r <= T_IDLE;
            end
            else
            begin
              step_r <= step_r + 4'h1;
              st_r <= T_SEND;
            end
          end
        default: st_r <= T_IDLE;
      endcase
    end
  end
  // serial engine: clock out, data open drain
  csic_i2c_wr #(.DEV_ADDR(DEV_ADDR)) u_wr (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .go_in(go_r),
    .reg_in(entry_r[15:8]),
    .data_in(entry_r[7:0]),
    .sda_in(sda_s2_r),
    .scl_out(scl_out),
    .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n_out),
    .done_out(eng_done),
    .nack_out(eng_nack)
  );
  assign programming_complete_out = done_r;
  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  // -----------------------------
  // assertions
  // -----------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  run_edge_a: assert property ((st_r == T_IDLE && $past(st_r) == T_IDLE) ##1 st_r == T_SEND |-> $past(trig_evt || pending_r))
    else $error("run started without trigger edge");
  done_clear_a: assert property (start_run |=> !done_r && st_r == T_SEND)
    else $error("done not cleared at run start");
  busy_done_a: assert property ((st_r != T_IDLE) |-> !done_r)
    else $error("done high during programming");
  done_rise_a: assert property ($rose(done_r) |-> $past(step_r) == `CSIC_LAST_STEP && $past(eng_done) && !$past(eng_nack))
    else $error("done raised before table finished");
  snap_sel_a: assert property (start_run |=> snap_r == $past(sel_eff))
    else $error("selects not captured at run start");
  xcvr_map_a: assert property ((go_r && step_r == 4'h1) |-> entry_r[7:0] == xcvr_div(xa))
    else $error("transceiver divider mismatch");
  mem_map_a: assert property ((go_r && step_r == 4'h4) |-> entry_r[7:0] == mem_div(mb))
    else $error("memory divider mismatch");
  apb_ready_a: assert property (setup |=> pready_r ##1 !pready_r)
    else $error("apb answer not one cycle");
  pend_keep_a: assert property ((trig_evt && st_r == T_WAIT) |=> pending_r)
    else $error("trigger during run lost");
  run_done_c: cover property ($rose(done_r));
  nack_c: cover property ($rose(nack_err_r));
  retrig_c: cover property (pending_r && start_run);
endmodule : csic_top

// ### csic_regs.svh
// offsets, field positions, reset values and timing counts of the
// clock synthesizer configurator; assumes a 10 MHz system clock
`ifndef CSIC_REGS_SVH
`define CSIC_REGS_SVH
// apb register byte offsets
`define CSIC_OFS_CTRL 8'h00
`define CSIC_OFS_STATUS 8'h04
// control register fields
`define CSIC_CTRL_START_BIT 0
`define CSIC_CTRL_SRC_BIT 1
`define CSIC_CTRL_SEL_LSB 4
`define CSIC_CTRL_SEL_MSB 19
`define CSIC_CTRL_RESET 32'h0000_0000
// status register fields
`define CSIC_STAT_DONE_BIT 0
`define CSIC_STAT_BUSY_BIT 1
`define CSIC_STAT_NACK_BIT 2
`define CSIC_STAT_STEP_LSB 8
// timing
`define CSIC_CLK_PERIOD_NS 100
`define CSIC_I2C_QUARTER_NS 2500
`define CSIC_QUARTER_CYC ((`CSIC_I2C_QUARTER_NS + `CSIC_CLK_PERIOD_NS - 1) / `CSIC_CLK_PERIOD_NS)
// synthesizer bus address and write table
`define CSIC_DEV_ADDR 7'h74
`define CSIC_LAST_STEP 4'h6
`define CSIC_REG_PREAMBLE 8'h10
`define CSIC_DAT_PREAMBLE 8'h01
`define CSIC_REG_CH_BASE 8'h20
`define CSIC_REG_UPDATE 8'h30
`define CSIC_DAT_UPDATE 8'h01
`define CSIC_REG_OUT_EN 8'h31
`define CSIC_DAT_OUT_EN 8'h0f
// transceiver divider codes: 644.53125, 322.265625, 250, 125, 100 MHz
`define CSIC_XDIV0 8'h01
`define CSIC_XDIV1 8'h02
`define CSIC_XDIV2 8'h03
`define CSIC_XDIV3 8'h04
`define CSIC_XDIV4 8'h05
// memory divider codes: 300, 275, 266.667, 233.333, 166.667 MHz
`define CSIC_MDIV0 8'h11
`define CSIC_MDIV1 8'h12
`define CSIC_MDIV2 8'h13
`define CSIC_MDIV3 8'h14
`define CSIC_MDIV4 8'h15
`endif

// ### csic_pkg.sv
// types shared by the configurator top and its serial write engine
// assumes nothing of its surroundings
package csic_pkg;
  typedef enum logic [1:0] {T_IDLE, T_SEND, T_WAIT} csic_top_state_t;
  typedef enum logic [1:0] {E_IDLE, E_START, E_BITS, E_STOP} csic_eng_state_t;
endpackage : csic_pkg

// ### csic_i2c_wr.sv
// serial write engine: start, address byte, register byte, data byte, stop
// assumes sda_in is already synchronised to clk_in and the line is pulled up
`timescale 1ns/1ps
`include "csic_regs.svh"
module csic_i2c_wr
  import csic_pkg::*;
#(
  parameter logic [7:0] QUARTER_CYC = 8'(`CSIC_QUARTER_CYC),
  parameter logic [6:0] DEV_ADDR = `CSIC_DEV_ADDR
)(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic go_in,            // one-cycle request
  input wire logic [7:0] reg_in,     // synthesizer register
  input wire logic [7:0] data_in,    // value to write
  input wire logic sda_in,           // synchronised line level
  output logic scl_out,
  output logic sda_out,
  output logic sda_oe_n_out,         // low while pulling the line low
  output logic done_out,             // one-cycle pulse at end
  output logic nack_out              // valid with done_out
);
  // -----------------------------
  // state
  // -----------------------------
  csic_eng_state_t st_r;
  logic [7:0] qcnt_r;                // quarter-period counter
  logic [1:0] ph_r;                  // quarter phase within a bit
  logic [3:0] bit_r;                 // 0..7 data, 8 ack
  logic [1:0] byte_r;                // 0 address, 1 register, 2 data
  logic [7:0] reg_r;
  logic [7:0] dat_r;
  logic nack_r;
  logic done_r;
  logic scl_r;
  logic oe_n_r;
  // -----------------------------
  // decode
  // -----------------------------
  wire tick = (st_r != E_IDLE) && (qcnt_r == QUARTER_CYC - 8'h01);
  wire [7:0] cur_byte = (byte_r == 2'h0) ? {DEV_ADDR, 1'b0} : (byte_r == 2'h1) ? reg_r : dat_r;
  wire cur_bit = cur_byte[3'(4'h7 - bit_r)];
  wire ack_slot = (bit_r == 4'h8);
  // quarter counter runs only during a transfer
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
      qcnt_r <= 8'h00;
    else
      qcnt_r <= (tick || st_r == E_IDLE) ? 8'h00 : qcnt_r + 8'h01;
  // sequencer
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_r <= E_IDLE;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      reg_r <= 8'h00;
      dat_r <= 8'h00;
      nack_r <= 1'b0;
      done_r <= 1'b0;
      scl_r <= 1'b1;
      oe_n_r <= 1'b1;
    end
    else
    begin
      done_r <= 1'b0;
      if (st_r == E_IDLE)
      begin
        scl_r <= 1'b1;
        oe_n_r <= 1'b1;
        if (go_in)
        begin
          // capture the pair and begin with a start condition
          reg_r <= reg_in;
          dat_r <= data_in;
          nack_r <= 1'b0;
          ph_r <= 2'h0;
          st_r <= E_START;
        end
      end
      else if (tick)
      begin
        ph_r <= ph_r + 2'h1;
        unique case (st_r)
          E_START:
          begin
            // data falls while clock is high, then clock falls
            if (ph_r == 2'h1) oe_n_r <= 1'b0;
            if (ph_r == 2'h2) scl_r <= 1'b0;
            if (ph_r == 2'h3)
            begin
              bit_r <= 4'h0;
              byte_r <= 2'h0;
              st_r <= E_BITS;
            end
          end
          E_BITS:
          begin
            if (ph_r == 2'h0) oe_n_r <= ack_slot ? 1'b1 : cur_bit;  // release to listen
            if (ph_r == 2'h1) scl_r <= 1'b1;
            if (ph_r == 2'h2 && ack_slot) nack_r <= sda_in;        // response sampled
            if (ph_r == 2'h3)
            begin
              scl_r <= 1'b0;
              if (!ack_slot)
                bit_r <= bit_r + 4'h1;
              else if (nack_r || byte_r == 2'h2)
                st_r <= E_STOP;
              else
              begin
                bit_r <= 4'h0;
                byte_r <= byte_r + 2'h1;
              end
            end
          end
          E_STOP:
          begin
            // data rises while clock is high
            if (ph_r == 2'h0) oe_n_r <= 1'b0;
            if (ph_r == 2'h1) scl_r <= 1'b1;
            if (ph_r == 2'h2) oe_n_r <= 1'b1;
            if (ph_r == 2'h3)
            begin
              done_r <= 1'b1;
              st_r <= E_IDLE;
            end
          end
          default: st_r <= E_IDLE;
        endcase
      end
    end
  end
  // open drain: only ever pull low
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;
  assign scl_out = scl_r;
  assign sda_oe_n_out = oe_n_r;
  assign done_out = done_r;
  assign nack_out = nack_r;
  // -----------------------------
  // assertions
  // -----------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sda_stable_a: assert property ((st_r == E_BITS && scl_r) |=> $stable(oe_n_r) || !scl_r)
    else $error("data line moved while clock high");
  ack_release_a: assert property ((st_r == E_BITS && ack_slot && ph_r != 2'h0) |-> oe_n_r)
    else $error("data line driven during acknowledge");
  start_cond_a: assert property ((st_r == E_START && ph_r == 2'h2) |-> (scl_r && !oe_n_r))
    else $error("start condition malformed");
endmodule : csic_i2c_wr

// ### csic_synth_model.sv
// synthesizer model: open-drain serial slave that logs every register write
// assumes the caller resolves the data wire with a pull-up
`timescale 1ns/1ps
module csic_synth_model (
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic nack_in,                // refuse every byte when high
  output logic sda_pull_out,               // high while holding the line low
  output logic [7:0] wr_cnt_out,           // count of completed writes
  output logic [7:0] st_cnt_out,           // count of start conditions seen
  output logic [7:0] log_adr_out [0:31],   // address byte of each write
  output logic [7:0] log_reg_out [0:31],   // register byte of each write
  output logic [7:0] log_dat_out [0:31]    // data byte of each write
);
  logic [7:0] shift_r;
  int bit_n = 0;
  int byte_n = 0;
  logic ack_slot = 1'b0;
  initial
  begin
    sda_pull_out = 1'b0;
    wr_cnt_out = 8'h00;
    st_cnt_out = 8'h00;
  end
  // start: data falls while clock high
  always @(negedge sda_in)
    if (scl_in === 1'b1)
    begin
      bit_n = 0;
      byte_n = 0;
      st_cnt_out = st_cnt_out + 8'h01;
    end
  // stop after three bytes logs the write
  always @(posedge sda_in)
    if (scl_in === 1'b1 && byte_n == 3)
    begin
      wr_cnt_out = wr_cnt_out + 8'h01;
      byte_n = 0;
    end
  // bits shift in on rising clock, msb first
  always @(posedge scl_in)
    if (bit_n < 8)
    begin
      shift_r = {shift_r[6:0], sda_in};
      bit_n = bit_n + 1;
    end
  // acknowledge slot opens after the eighth bit, closes one bit later
  always @(negedge scl_in)
    if (ack_slot)
    begin
      ack_slot = 1'b0;
      sda_pull_out = 1'b0;
      bit_n = 0;
    end
    else if (bit_n == 8)
    begin
      ack_slot = 1'b1;
      sda_pull_out = !nack_in;
      case (byte_n)
        0: log_adr_out[wr_cnt_out] = shift_r;
        1: log_reg_out[wr_cnt_out] = shift_r;
        default: log_dat_out[wr_cnt_out] = shift_r;
      endcase
      byte_n = byte_n + 1;
    end
endmodule : csic_synth_model

// ### csic_top_tb.sv
// bench: pin and register runs, refusals, static trigger, aborted run
// assumes the synthesizer model sits on the serial pins
`timescale 1ns/1ps
`include "csic_regs.svh"
module csic_top_tb;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic trig = 1'b0;
  logic [3:0] xa = 4'h0;
  logic [3:0] xb = 4'h0;
  logic [3:0] ma = 4'h0;
  logic [3:0] mb = 4'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic done, scl, sda_o, oe_n, pready, pslverr, nack, pull;
  logic [31:0] prdata;
  logic [7:0] wr_cnt;
  logic [7:0] st_cnt;
  logic [7:0] l_adr [0:31];
  logic [7:0] l_reg [0:31];
  logic [7:0] l_dat [0:31];
  wire sda_line = (!oe_n || pull) ? 1'b0 : 1'b1;  // pulled-up open drain
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] xtab [0:4] = '{`CSIC_XDIV0, `CSIC_XDIV1, `CSIC_XDIV2, `CSIC_XDIV3, `CSIC_XDIV4};
  logic [7:0] mtab [0:4] = '{`CSIC_MDIV0, `CSIC_MDIV1, `CSIC_MDIV2, `CSIC_MDIV3, `CSIC_MDIV4};
  logic [31:0] rd;
  logic er;
  initial nack = 1'b0;
  always #50 clk_in = ~clk_in;
  csic_top csic_top_i (.clk_in(clk_in), .rstn_in(rstn_in), .config_trigger_in(trig),
    .transceiver_freq_sel_a_in(xa), .transceiver_freq_sel_b_in(xb), .memory_freq_sel_a_in(ma),
    .memory_freq_sel_b_in(mb), .programming_complete_out(done), .scl_out(scl), .sda_in(sda_line),
    .sda_out(sda_o), .sda_oe_n_out(oe_n), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));
  csic_synth_model csic_synth_model_i (.scl_in(scl), .sda_in(sda_line), .nack_in(nack),
    .sda_pull_out(pull), .wr_cnt_out(wr_cnt), .st_cnt_out(st_cnt), .log_adr_out(l_adr),
    .log_reg_out(l_reg), .log_dat_out(l_dat));
  // ----------------------------------------
  // compare, report and bus tasks
  // ----------------------------------------
  task end_of_test;
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_word
  // one apb transfer, held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1)
      @(posedge clk_in);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // waits for a run and checks the seven logged writes
  task wait_run(input logic [7:0] base, input logic [3:0] a, b, c, d);
    logic [7:0] ed [0:6];
    int n;
    ed = '{`CSIC_DAT_PREAMBLE, xtab[a > 4 ? 0 : a], xtab[b > 4 ? 0 : b], mtab[c > 4 ? 0 : c],
      mtab[d > 4 ? 0 : d], `CSIC_DAT_UPDATE, `CSIC_DAT_OUT_EN};
    n = 0;
    while (done !== 1'b0 && n < 20)
    begin
      @(posedge clk_in);
      n++;
    end
    chk_word(32'(done), 32'h0);
    while (done !== 1'b1)
      @(posedge clk_in);
    chk_word(32'(wr_cnt), 32'(base + 8'h07));
    for (int i = 0; i < 7; i++)
    begin
      chk_word(32'(l_adr[base + i]), 32'({`CSIC_DEV_ADDR, 1'b0}));
      chk_word(32'(l_reg[base + i]), (i == 0) ? 32'(`CSIC_REG_PREAMBLE) : (i < 5) ?
        32'(`CSIC_REG_CH_BASE + i - 1) : 32'(`CSIC_REG_UPDATE + i - 5));
      chk_word(32'(l_dat[base + i]), 32'(ed[i]));
    end
  endtask : wait_run
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    chk_word({done, scl, oe_n, sda_o, pready}, 32'h0c);
  endtask : t_reset
  task t_regs;
    apb(1'b0, `CSIC_OFS_CTRL, 32'h0);
    chk_word(rd, 32'h0);
    chk_word(32'(er), 32'h0);
    apb(1'b1, `CSIC_OFS_STATUS, 32'h1);
    chk_word(32'(er), 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    chk_word(rd, 32'h0);
    chk_word(32'(er), 32'h1);
  endtask : t_regs
  task pin_run(input logic [3:0] a, b, c, d);
    @(posedge clk_in);
    trig <= 1'b0;
    xa <= a;
    xb <= b;
    ma <= c;
    mb <= d;
    repeat (5) @(posedge clk_in);
    trig <= 1'b1;
    wait_run(wr_cnt, a, b, c, d);
  endtask : pin_run
  task t_static;
    logic [7:0] base;
    base = wr_cnt;
    repeat (300) @(posedge clk_in);
    chk_word({done, wr_cnt}, {1'b1, base});
  endtask : t_static
  task t_apb_run;
    logic [7:0] base;
    logic [31:0] cw;
    base = wr_cnt;
    cw = {12'h0, 4'h9, 4'h4, 4'h0, 4'h4, 4'h3};
    apb(1'b1, `CSIC_OFS_CTRL, cw);
    wait_run(base, 4'h4, 4'h0, 4'h4, 4'h9);
    apb(1'b0, `CSIC_OFS_CTRL, 32'h0);
    chk_word(rd, cw);
    apb(1'b0, `CSIC_OFS_STATUS, 32'h0);
    chk_word(rd & 32'h7, 32'h1);
    apb(1'b1, `CSIC_OFS_CTRL, 32'h0);
  endtask : t_apb_run
  task t_nack;
    logic [7:0] base;
    logic [7:0] sb;
    int n;
    base = wr_cnt;
    sb = st_cnt;
    nack <= 1'b1;
    trig <= 1'b0;
    repeat (5) @(posedge clk_in);
    trig <= 1'b1;
    // a second edge while the refused run is under way is queued
    repeat (100) @(posedge clk_in);
    trig <= 1'b0;
    repeat (5) @(posedge clk_in);
    trig <= 1'b1;
    n = 0;
    rd = 32'h0;
    while ((rd[2] !== 1'b1 || st_cnt !== sb + 8'h02) && n < 200)
    begin
      repeat (50) @(posedge clk_in);
      apb(1'b0, `CSIC_OFS_STATUS, 32'h0);
      n++;
    end
    chk_word({rd[2], done, wr_cnt}, {2'b10, base});
    chk_word(32'(st_cnt), 32'(sb + 8'h02));
    nack <= 1'b0;
  endtask : t_nack
  // ----------------------------------------
  // main sequence and hang guard
  // ----------------------------------------
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 85000)
    begin
      failures++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (4) @(posedge clk_in);
    t_reset;
    rstn_in <= 1'b1;
    t_regs;
    pin_run(4'h0, 4'h1, 4'h0, 4'h1);
    t_static;
    pin_run(4'h2, 4'h3, 4'h2, 4'h3);
    t_apb_run;
    t_nack;
    end_of_test;
  end
endmodule : csic_top_tb
